// *** dv/pin_block_tb.sv ***
/*
 * Self-checking bench for the pin block with a board model.
 * Assumes a debounce tick of 4 cycles and a 1 us slew flag.
 */
`timescale 1ns/1ps
`default_nettype none
module pin_block_tb;
	logic       clk = 1'h0;
	logic       sys_rst = 1'h1;
	logic [3:0] reg_sel = 4'h0;
	logic       reg_wr = 1'h0;
	logic       reg_rd = 1'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata_q;
	logic [7:0] pin_lvl;
	logic [7:0] ext = 8'h00;
	logic [7:0] bo, boe, gen;
	logic [3:0] so, soe, slw;
	logic       evt;
	logic [7:0] d, r, eo, ee;
	int         num_errors = 0;
	int         samples_checked = 0;
	int         mdl[16];

	// Free-running 100 MHz clock.
	always #5 clk = ~clk;

	pin_board brd (.pin_out(bo), .pin_oe(boe), .ext_lvl(ext), .wire_lvl(pin_lvl));

	pin_block #(.DEB_TICK_CYCLES(4)) dut (
		.clk(clk), .sys_rst(sys_rst), .reg_sel(reg_sel), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
		.bidir_pin_in(pin_lvl), .bidir_pin_out_q(bo), .bidir_pin_oe_q(boe),
		.switch_gate_out_q(so), .switch_gate_oe_q(soe), .switch_gate_slew_q(slw),
		.general_output_only_q(gen), .gpio_event_q(evt));

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr(input logic [3:0] s, input logic [7:0] v);
		@(negedge clk);
		reg_sel = s;
		reg_wdata = v;
		reg_wr = 1'h1;
		@(negedge clk);
		reg_wr = 1'h0;
	endtask : wr

	task automatic rd(input logic [3:0] s, output logic [7:0] v);
		@(negedge clk);
		reg_sel = s;
		reg_rd = 1'h1;
		@(negedge clk);
		reg_rd = 1'h0;
		v = reg_rdata_q;
	endtask : rd

	task automatic wrap_up();
		if (num_errors == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : wrap_up

	// Watchdog sized well above the expected run length.
	initial begin
		#400000;
		num_errors++;
		wrap_up();
	end

	// Main sequence.
	initial begin
		void'($urandom(88421));
		repeat (12) @(negedge clk);
		sys_rst = 1'h0;
		chk(boe, 8'h00);
		chk({soe, so}, 8'hF0);
		chk(gen, 8'h00);
		rd(4'h0, d);
		chk(d, 8'h02);
		for (int i = 0; i < 8; i++) begin
			r = 8'($urandom) & 8'h0B;
			mdl[i] = r;
			wr(4'(i), r);
			@(negedge clk);
			ee = (r[1] ? 8'h00 : (r[0] ? 8'h01 : {7'h0, ~r[3]})) << i;
			eo = {7'h0, ~r[1] & r[0] & r[3]} << i;
			chk(boe & (8'h01 << i), ee);
			chk(bo & (8'h01 << i), eo);
			rd(4'(i), d);
			chk(d & (r[1] ? 8'hFF : 8'hFB), 8'(mdl[i]));
		end
		for (int i = 0; i < 4; i++) begin
			r = 8'($urandom) & 8'h09;
			ee = {7'h0, r[0] | ~r[3]};
			eo = {7'h0, r[0] & r[3]};
			wr(4'(8 + i), r | 8'hF6);
			@(negedge clk);
			chk({7'h0, soe[i]}, ee);
			chk({7'h0, so[i]}, eo);
			@(negedge clk);
			chk({4'h0, slw}, {7'h0, ee != 8'h01 || eo != 8'h00} << i);
			rd(4'(8 + i), d);
			chk(d, r);
			repeat (110) @(negedge clk);
			chk({4'h0, slw}, 8'h00);
		end
		r = 8'($urandom);
		wr(4'hC, r);
		@(negedge clk);
		chk(gen, r);
		rd(4'hC, d);
		chk(d, r);
		for (int s = 13; s < 16; s++) begin
			wr(4'(s), 8'hFF);
			rd(4'(s), d);
			chk(d, 8'h00);
		end
		// edges, glitch rejection and sampled level on pin 3
		for (int e = 0; e < 3; e++) begin
			ext[3] = 1'h0;
			wr(4'h3, 8'(8'h02 | (e << 4)));
			repeat (40) @(negedge clk);
			wr(4'h3, 8'(8'h42 | (e << 4)));
			ext[3] = 1'h1;
			repeat (6) @(negedge clk);
			ext[3] = 1'h0;
			repeat (40) @(negedge clk);
			rd(4'h3, d);
			chk(d, 8'(8'h02 | (e << 4)));
			ext[3] = 1'h1;
			repeat (40) @(negedge clk);
			rd(4'h3, d);
			chk(d, 8'(8'h06 | (e << 4) | ((e == 2) << 6)));
			chk({7'h0, evt}, 8'(e == 2));
			wr(4'h3, 8'(8'h42 | (e << 4)));
			ext[3] = 1'h0;
			repeat (40) @(negedge clk);
			rd(4'h3, d);
			chk(d, 8'(8'h02 | (e << 4) | ((e == 1) << 6)));
			chk({7'h0, evt}, 8'(e == 1));
			wr(4'h3, 8'(8'h42 | (e << 4)));
			repeat (3) @(negedge clk);
			chk({7'h0, evt}, 8'h00);
		end
		wrap_up();
	end
endmodule : pin_block_tb
`default_nettype wire

// *** dv/pin_board.sv ***
/*
 * Board model for the bidirectional pins: resolves each wire from the
 * pin driver and the board's own level. Assumes ext_lvl is a pull or
 * an external driver that yields while the pin drives.
 */
`timescale 1ns/1ps
`default_nettype none
module pin_board (
	// Pin driver side.
	input  wire logic [7:0] pin_out,
	input  wire logic [7:0] pin_oe,
	// Board side.
	input  wire logic [7:0] ext_lvl,
	output logic      [7:0] wire_lvl
);
	// driven wins: an enabled driver sets the wire, else the board does.
	assign wire_lvl = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule : pin_board
`default_nettype wire

// *** hdl/debounce_if.sv ***
/*
 * Carries the raw bidirectional pin levels to the debounce filter and
 * the filtered levels back. Assumes both ends share one clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface debounce_if;
	logic [7:0] raw;
	logic [7:0] clean;
	modport filter (input raw, output clean);
	modport core   (output raw, input clean);
endinterface : debounce_if
`default_nettype wire

// *** hdl/input_debounce.sv ***
/*
 * Debounce filter for the bidirectional pin inputs. A divider makes a
 * tick enable; a level is accepted once it has differed from the clean
 * level on DEB_TICKS consecutive ticks. Assumes synchronous inputs.
 */
`timescale 1ns/1ps
`default_nettype none
module input_debounce #(
	parameter int unsigned TICK_CYCLES = pin_block_pkg::DEB_TICK_CYC
) (
	// Clock and reset.
	input wire logic   clk,
	input wire logic   sys_rst,
	// Raw and filtered levels.
	debounce_if.filter dbi
);
	localparam int unsigned DIV_W = $clog2(TICK_CYCLES + 1);

	logic [DIV_W-1:0] div_q;
	logic             tick_q;
	logic [7:0]       clean_w;

	// Tick divider; one tick per period keeps all eight filters in step.
	always_ff @(posedge clk) begin
		if (sys_rst || div_q == DIV_W'(TICK_CYCLES - 1)) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + DIV_W'(1);
		end
	end

	// Tick pulse, one cycle wide.
	always_ff @(posedge clk) begin
		tick_q <= !sys_rst && div_q == DIV_W'(TICK_CYCLES - 1);
	end

	genvar i;
	generate
		for (i = 0; i < pin_block_pkg::NUM_BIDIR; i++) begin : g_bit
			logic [pin_block_pkg::DEB_CNT_W-1:0] cnt_q;
			logic                                clean_q;
			// stable window: several ticks in a row before acceptance.
			always_ff @(posedge clk) begin
				if (sys_rst) begin
					cnt_q   <= '0;
					clean_q <= 1'h0;
				end else if (tick_q) begin
					if (dbi.raw[i] == clean_q) begin
						cnt_q <= '0;
					end else if (cnt_q == pin_block_pkg::DEB_CNT_W'(pin_block_pkg::DEB_TICKS - 1)) begin
						cnt_q   <= '0;
						clean_q <= dbi.raw[i];
					end else begin
						cnt_q <= cnt_q + pin_block_pkg::DEB_CNT_W'(1);
					end
				end
			end
			assign clean_w[i] = clean_q;
		end
	endgenerate

	assign dbi.clean = clean_w;

	a_deb_on_tick: assert property (@(posedge clk) disable iff (sys_rst)
		$changed(clean_w) |-> $past(tick_q))
		else $error("Clean level changed off a tick.");

endmodule : input_debounce
`default_nettype wire

// *** hdl/pin_block.sv ***
/*
 * General purpose pin block: eight bidirectional pins, four slew
 * controlled switch gates and eight push-pull outputs; each pin and gate is
 * steered by an 8-bit control and status register, the outputs by one shared level byte, on a plain register port.
 * Assumes one 100 MHz clock and pin inputs synchronous to it.
 */
// Overview of operation
// - Eight bidirectional pins, four switch gates, eight outputs; only bidirectional pins sense.
// - Bidirectional pins and switch gates are push-pull or open-drain; outputs push-pull.
// - Reset: pins are inputs, switch gates open-drain low, outputs push-pull low.
// - Each bidirectional pin and switch gate owns one 8-bit control register.
// - Bit 0 picks open-drain or push-pull; bit 1 set makes an input.
// - Bit 2 returns the debounced pin level captured when a read starts.
// - In output mode the host treats the sampled level bit as invalid.
// - Inputs are debounced over a window no longer than ten milliseconds.
// - Switch gates ramp their drive on every change; others switch plainly.
// - Output level bit sets drive; kept but unused while the pin is input.
// - Edge field masked, falling or rising sets pin flag and block event.
`timescale 1ns/1ps
`default_nettype none
module pin_block #(
	parameter int unsigned DEB_TICK_CYCLES = pin_block_pkg::DEB_TICK_CYC
) (
	// Clock and reset.
	input  wire logic       clk,
	input  wire logic       sys_rst,
	// Register port.
	input  wire logic [3:0] reg_sel,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata_q,
	// Bidirectional pins.
	input  wire logic [7:0] bidir_pin_in,
	output logic      [7:0] bidir_pin_out_q,
	output logic      [7:0] bidir_pin_oe_q,
	// Switch gate outputs.
	output logic      [3:0] switch_gate_out_q,
	output logic      [3:0] switch_gate_oe_q,
	output logic      [3:0] switch_gate_slew_q,
	// General outputs and event to the first-level interrupt logic.
	output logic      [7:0] general_output_only_q,
	output logic            gpio_event_q
);
	logic [7:0] bidir_type;
	logic [7:0] bidir_dir;
	logic [7:0] bidir_lvl;
	logic [7:0] bidir_flag;
	logic [3:0] sw_type;
	logic [3:0] sw_lvl;
	logic [3:0] sw_oe_d;
	logic [3:0] sw_out_d;
	logic [7:0] clean_prev_q;
	logic [7:0] rd_words [pin_block_pkg::NUM_REGS];

	debounce_if dbi ();
	assign dbi.raw = bidir_pin_in;

	input_debounce #(
		.TICK_CYCLES (DEB_TICK_CYCLES)
	) u_debounce (
		.clk     (clk),
		.sys_rst (sys_rst),
		.dbi     (dbi)
	);

	// Write decode: general output strobe, plus edge and clear fields shared by the bidirectional pins.
	wire       gen_wr   = reg_wr && reg_sel == pin_block_pkg::REG_GEN;
	wire [1:0] wr_itype = reg_wdata[pin_block_pkg::IRQ_MSB:pin_block_pkg::IRQ_LSB];
	wire       wr_clr   = reg_wdata[pin_block_pkg::BIT_FLAG];

	genvar i;
	generate
		for (i = 0; i < pin_block_pkg::NUM_BIDIR; i++) begin : g_bidir
			logic       type_q;
			logic       dir_q;
			logic       lvl_q;
			logic [1:0] itype_q;
			logic       flag_q;
			wire wr_hit = reg_wr && reg_sel == pin_block_pkg::REG_IDX_W'(i);
			wire fall   = clean_prev_q[i] && !dbi.clean[i];
			wire rise   = !clean_prev_q[i] && dbi.clean[i];
			// edge select, only while the pin senses.
			wire hit    = dir_q && ((itype_q == pin_block_pkg::IRQ_FALL && fall)
				|| (itype_q == pin_block_pkg::IRQ_RISE && rise));

			// reset as input; fields load on write.
			always_ff @(posedge clk) begin
				if (sys_rst) begin
					type_q  <= pin_block_pkg::RST_TYPE;
					dir_q   <= pin_block_pkg::RST_BIDIR_DIR;
					lvl_q   <= pin_block_pkg::RST_LVL;
					itype_q <= pin_block_pkg::IRQ_MASKED;
				end else if (wr_hit) begin
					type_q  <= reg_wdata[pin_block_pkg::BIT_TYPE];
					dir_q   <= reg_wdata[pin_block_pkg::BIT_DIR];
					lvl_q   <= reg_wdata[pin_block_pkg::BIT_LVL_OUT];
					itype_q <= wr_itype;
				end
			end

			// sticky flag; a new edge wins over a write-one clear.
			always_ff @(posedge clk) begin
				if (sys_rst) begin
					flag_q <= 1'h0;
				end else begin
					flag_q <= hit || (flag_q && !(wr_hit && wr_clr));
				end
			end

			assign bidir_type[i] = type_q;
			assign bidir_dir[i]  = dir_q;
			assign bidir_lvl[i]  = lvl_q;
			assign bidir_flag[i] = flag_q;
			// sampled level; it is still returned in output mode.
			assign rd_words[i] = {1'h0, flag_q, itype_q, lvl_q, dbi.clean[i], dir_q, type_q};

			a_flag_on_edge: assert property (@(posedge clk) disable iff (sys_rst)
				hit |=> flag_q)
				else $error("Selected edge did not set the pin flag.");
		end

		for (i = 0; i < pin_block_pkg::NUM_SW; i++) begin : g_sw
			logic                              type_q;
			logic                              lvl_q;
			logic [pin_block_pkg::SLEW_CNT_W-1:0] ramp_q;
			wire wr_hit = reg_wr && reg_sel == pin_block_pkg::REG_SW_BASE + 4'(i);
			wire chg    = switch_gate_out_q[i] != sw_out_d[i] || switch_gate_oe_q[i] != sw_oe_d[i];

			// open-drain low at reset; no direction or input path.
			always_ff @(posedge clk) begin
				if (sys_rst) begin
					type_q <= pin_block_pkg::RST_TYPE;
					lvl_q  <= pin_block_pkg::RST_LVL;
				end else if (wr_hit) begin
					type_q <= reg_wdata[pin_block_pkg::BIT_TYPE];
					lvl_q  <= reg_wdata[pin_block_pkg::BIT_LVL_OUT];
				end
			end

			// slew ramp: the driver runs weak for a while after each change.
			always_ff @(posedge clk) begin
				if (sys_rst) begin
					ramp_q                <= '0;
					switch_gate_slew_q[i] <= 1'h0;
				end else if (chg) begin
					ramp_q                <= pin_block_pkg::SLEW_CNT_W'(pin_block_pkg::SLEW_CYC - 1);
					switch_gate_slew_q[i] <= 1'h1;
				end else begin
					ramp_q                <= ramp_q - pin_block_pkg::SLEW_CNT_W'(ramp_q != '0);
					switch_gate_slew_q[i] <= ramp_q > pin_block_pkg::SLEW_CNT_W'(1);
				end
			end

			assign sw_type[i] = type_q;
			assign sw_lvl[i]  = lvl_q;
			assign rd_words[pin_block_pkg::REG_SW_BASE + i] = {4'h0, lvl_q, 2'h0, type_q};

			a_slew_on_change: assert property (@(posedge clk) disable iff (sys_rst)
				chg |=> switch_gate_slew_q[i] [*2])
				else $error("Switch gate changed without a slew ramp.");
		end
	endgenerate

	// general outputs read back their level byte.
	assign rd_words[pin_block_pkg::REG_GEN] = general_output_only_q;

	// open-drain releases for high, push-pull drives both levels.
	wire [7:0] bidir_oe_d  = ~bidir_dir & (bidir_type | ~bidir_lvl);
	wire [7:0] bidir_out_d = ~bidir_dir & bidir_type & bidir_lvl;
	assign sw_oe_d         = sw_type | ~sw_lvl;
	assign sw_out_d        = sw_type & sw_lvl;
	wire [7:0] rd_mux      = reg_sel <= pin_block_pkg::REG_GEN ? rd_words[reg_sel] : 8'h00;

	// pin drivers reset: bidirectional pins to input, switch gates to open-drain low.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			bidir_pin_oe_q    <= 8'h00;
			bidir_pin_out_q   <= 8'h00;
			switch_gate_oe_q  <= 4'hF;
			switch_gate_out_q <= 4'h0;
		end else begin
			bidir_pin_oe_q    <= bidir_oe_d;
			bidir_pin_out_q   <= bidir_out_d;
			switch_gate_oe_q  <= sw_oe_d;
			switch_gate_out_q <= sw_out_d;
		end
	end

	// general output levels; always driven, push-pull only.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			general_output_only_q <= pin_block_pkg::RST_GEN;
		end else if (gen_wr) begin
			general_output_only_q <= reg_wdata;
		end
	end

	// read data is captured on the cycle the read starts and then held.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			reg_rdata_q <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata_q <= rd_mux;
		end
	end

	// edge history and the block event toward the first-level register.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			clean_prev_q <= 8'h00;
			gpio_event_q <= 1'h0;
		end else begin
			clean_prev_q <= dbi.clean;
			gpio_event_q <= |bidir_flag;
		end
	end

	a_reset_defaults: assert property (@(posedge clk)
		sys_rst |=> bidir_pin_oe_q == 8'h00 && switch_gate_oe_q == 4'hF
			&& switch_gate_out_q == 4'h0 && general_output_only_q == 8'h00
			&& bidir_pin_out_q == 8'h00 && switch_gate_slew_q == 4'h0)
		else $error("Pins not in their reset state.");

	a_drain_never_high: assert property (@(posedge clk) disable iff (sys_rst)
		((bidir_pin_out_q & ~$past(bidir_type)) == 8'h00)
			&& ((switch_gate_out_q & ~$past(sw_type)) == 4'h0))
		else $error("Open-drain pin driven high.");

	a_input_released: assert property (@(posedge clk) disable iff (sys_rst)
		(bidir_pin_oe_q & $past(bidir_dir)) == 8'h00)
		else $error("Input pin is being driven.");

	a_type_write: assert property (@(posedge clk) disable iff (sys_rst)
		reg_wr && reg_sel < pin_block_pkg::REG_SW_BASE |=>
			bidir_type[$past(reg_sel[2:0])] == $past(reg_wdata[0]) ##1
			bidir_pin_oe_q == bidir_oe_d || $past(reg_wr))
		else $error("Output type write did not land.");

	a_read_level: assert property (@(posedge clk) disable iff (sys_rst)
		reg_rd && reg_sel < pin_block_pkg::REG_SW_BASE |=>
			reg_rdata_q[2] == $past(dbi.clean[reg_sel[2:0]]))
		else $error("Read did not return the sampled level.");

	a_gen_write: assert property (@(posedge clk) disable iff (sys_rst)
		gen_wr |=> general_output_only_q == $past(reg_wdata))
		else $error("General output write did not land.");

	a_event_out: assert property (@(posedge clk) disable iff (sys_rst)
		(|bidir_flag) |=> gpio_event_q)
		else $error("Pin flag did not raise the block event.");

	a_sw_no_sense: assert property (@(posedge clk) disable iff (sys_rst)
		reg_rd && reg_sel >= pin_block_pkg::REG_SW_BASE && reg_sel < pin_block_pkg::REG_GEN
			|=> reg_rdata_q[2:1] == 2'h0)
		else $error("Switch gate reported an input path.");

	c_flag_raised: cover property (@(posedge clk) disable iff (sys_rst)
		$rose(gpio_event_q));
	c_bidir_pushpull: cover property (@(posedge clk) disable iff (sys_rst)
		|(bidir_pin_out_q & bidir_pin_oe_q));
	c_slew_ramp: cover property (@(posedge clk) disable iff (sys_rst)
		$fell(switch_gate_slew_q[0]));

endmodule : pin_block
`default_nettype wire

// *** hdl/pin_block_pkg.sv ***
/*
 * Shared constants of the pin block: register indices, bit positions
 * of the control and status byte, reset values and timing counts.
 * Assumes a single 100 MHz clock.
 */
`default_nettype none
package pin_block_pkg;

	// Pin counts.
	localparam int unsigned NUM_BIDIR = 8;
	localparam int unsigned NUM_SW    = 4;
	localparam int unsigned NUM_GEN   = 8;

	// Register index space: bidirectional pins, then switch gates, then outputs.
	localparam int unsigned REG_IDX_W   = 4;
	localparam logic [3:0]  REG_SW_BASE = 4'h8;
	localparam logic [3:0]  REG_GEN     = 4'hC;
	localparam int unsigned NUM_REGS    = 13;

	// Bit positions of the control and status byte.
	localparam int unsigned BIT_TYPE    = 0;
	localparam int unsigned BIT_DIR     = 1;
	localparam int unsigned BIT_LVL_IN  = 2;
	localparam int unsigned BIT_LVL_OUT = 3;
	localparam int unsigned IRQ_LSB     = 4;
	localparam int unsigned IRQ_MSB     = 5;
	localparam int unsigned BIT_FLAG    = 6;

	// Interrupt edge selection.
	typedef enum logic [1:0] {
		IRQ_MASKED = 2'h0,
		IRQ_FALL   = 2'h1,
		IRQ_RISE   = 2'h2
	} irq_type_e;

	// Reset values of the fields.
	localparam logic       RST_TYPE     = 1'h0;
	localparam logic       RST_BIDIR_DIR = 1'h1;
	localparam logic       RST_LVL      = 1'h0;
	localparam logic [7:0] RST_GEN      = 8'h00;

	// Timing: clock, debounce tick and slew ramp.
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned DEB_TICK_NS   = 1000000;
	localparam int unsigned DEB_TICK_CYC  = DEB_TICK_NS / CLK_PERIOD_NS;
	localparam int unsigned DEB_TICKS     = 4;
	localparam int unsigned DEB_CNT_W     = 2;
	localparam int unsigned SLEW_TIME_NS  = 1000;
	localparam int unsigned SLEW_CYC      = SLEW_TIME_NS / CLK_PERIOD_NS;
	localparam int unsigned SLEW_CNT_W    = 7;

endpackage : pin_block_pkg
`default_nettype wire
